// ### src/ecsd_pkg.sv
// Shared constants and types for the external chip-select decoder
package ecsd_pkg;

  localparam int ADDR_W = 26;
  localparam int PIN_ADDR_W = 21;
  localparam int DATA_W = 8;

  // Decode windows, inclusive bounds
  localparam logic [25:0] BOOT_LO = 26'h000_0000;
  localparam logic [25:0] BOOT_HI = 26'h03F_FFFF;
  localparam logic [25:0] RAM_LO = 26'h040_0000;
  localparam logic [25:0] RAM_HI = 26'h07F_FFFF;
  localparam logic [25:0] TWO_LO = 26'h080_0000;
  localparam logic [25:0] TWO_HI = 26'h0BF_FFFF;
  localparam logic [25:0] FOUR_LO = 26'h100_0000;
  localparam logic [25:0] FOUR_HI = 26'h13F_FFFF;
  localparam logic [25:0] FIVE_LO = 26'h140_0000;
  localparam logic [25:0] FIVE_HI = 26'h17F_FFFF;
  localparam logic [25:0] ISA_LO = 26'h340_0000;
  localparam logic [25:0] ISA_HI = 26'h37F_FFFF;

  // Strobe phase lasts STROBE_LAST + 1 cycles before the wait input counts
  localparam logic [1:0] STROBE_LAST = 2'h2;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_SETUP = 3'h1,
    ST_STROBE = 3'h3,
    ST_HOLD = 3'h2,
    ST_DONE = 3'h6
  } ecsd_state_t;

  typedef struct packed {
    logic write;
    logic [25:0] addr;
    logic [7:0] wdata;
  } ecsd_req_t;

  typedef struct packed {
    logic boot;
    logic ram;
    logic two;
    logic four;
    logic five;
  } ecsd_sel_t;

  typedef struct packed {
    logic sel4_isa;
    logic sel5_isa;
    logic [4:0] wait_en;
    logic pb4_alt;
    logic pb5_alt;
  } ecsd_cfg_t;

  typedef struct packed {
    ecsd_state_t st;
    logic [1:0] cnt;
    ecsd_req_t req;
    ecsd_sel_t sel;
    logic isa4;
    logic isa5;
    ecsd_sel_t cs_n;
    logic re_n;
    logic we_n;
    logic [7:0] rdata;
    logic resp;
    logic pb4_alt;
    logic pb5_alt;
    logic wait_m;
    logic wait_s;
    logic ext_m;
    logic ext_s;
    logic pb4_m;
    logic pb4_s;
    logic pb5_m;
    logic pb5_s;
    logic [20:0] a_m;
    logic [20:0] a_s;
    logic [7:0] d_m;
    logic [7:0] d_s;
  } ecsd_regs_t;

  function automatic logic in_win(logic [25:0] a, logic [25:0] lo,
                                  logic [25:0] hi);
    return (a >= lo) && (a <= hi);
  endfunction

endpackage

// ### src/ecsd_decode.sv
// Address window decoder producing at most one select
module ecsd_decode (
  input wire logic [25:0] addr,
  input wire logic write,
  input wire logic isa4,
  input wire logic isa5,
  output ecsd_pkg::ecsd_sel_t sel
);

  always_comb begin
    sel.boot = ecsd_pkg::in_win(addr, ecsd_pkg::BOOT_LO,
                                ecsd_pkg::BOOT_HI);
    sel.ram = ecsd_pkg::in_win(addr, ecsd_pkg::RAM_LO,
                               ecsd_pkg::RAM_HI);
    sel.two = ecsd_pkg::in_win(addr, ecsd_pkg::TWO_LO,
                               ecsd_pkg::TWO_HI);
    // Strobe mode replaces the ordinary window entirely
    if (isa4) begin
      sel.four = !write && ecsd_pkg::in_win(addr, ecsd_pkg::ISA_LO,
                                            ecsd_pkg::ISA_HI);
    end else begin
      sel.four = ecsd_pkg::in_win(addr, ecsd_pkg::FOUR_LO,
                                  ecsd_pkg::FOUR_HI);
    end
    if (isa5) begin
      sel.five = write && ecsd_pkg::in_win(addr, ecsd_pkg::ISA_LO,
                                           ecsd_pkg::ISA_HI);
    end else begin
      sel.five = ecsd_pkg::in_win(addr, ecsd_pkg::FIVE_LO,
                                  ecsd_pkg::FIVE_HI);
    end
  end

endmodule

// ### src/ecsd_top.sv
// External memory bus cycle engine with chip selects and ISA strobes
//
// How it works
// - Boot select covers 0x0000_0000 to 0x003F_FFFF.
// - Post-reset configuration fetches go through boot select.
// - RAM select covers 0x0040_0000 to 0x007F_FFFF.
// - Select two covers 0x0080_0000 to 0x00BF_FFFF.
// - Select four ordinary window 0x0100_0000 upward.
// - Select four strobes ISA-window reads only.
// - Select five ordinary window 0x0140_0000 upward.
// - Select five strobes ISA-window writes only.
// - Port B bit four is GPIO after reset.
// - Port B bit five is GPIO after reset.
// - Address pins driven by us, else external input.
// - Data pins driven on writes, released on reads.
// - Eight-bit data, one byte per cycle.
// - Direction outputs show write high, inverse pair.
// - Enabled wait input stretches cycle without limit.
// - Read strobe only after address valid; after select valid except ISA strobes.
module ecsd_top (
  input wire logic clock,
  input wire logic srst,
  input ecsd_pkg::ecsd_cfg_t cfg,
  input wire logic req_valid,
  input ecsd_pkg::ecsd_req_t req,
  output logic req_ready,
  output logic resp_valid,
  output logic [7:0] resp_rdata,
  input wire logic gpio_b4_o,
  input wire logic gpio_b4_oe,
  output logic gpio_b4_i,
  input wire logic gpio_b5_o,
  input wire logic gpio_b5_oe,
  output logic gpio_b5_i,
  input wire logic ext_master_req,
  output logic ext_master_active,
  output logic [20:0] ext_addr,
  output logic [20:0] addr_o,
  output logic addr_oe,
  input wire logic [20:0] addr_i,
  output logic [7:0] data_o,
  output logic data_oe,
  input wire logic [7:0] data_i,
  output logic boot_select_n,
  output logic ram_select_n,
  output logic select_two_n,
  output logic port_b_bit_four_o,
  output logic port_b_bit_four_oe,
  input wire logic port_b_bit_four_i,
  output logic port_b_bit_five_o,
  output logic port_b_bit_five_oe,
  input wire logic port_b_bit_five_i,
  output logic write_not_read,
  output logic read_not_write,
  output logic read_strobe_n,
  output logic write_strobe_n,
  input wire logic cycle_wait_n
);

  ecsd_pkg::ecsd_regs_t q;
  ecsd_pkg::ecsd_regs_t d;
  ecsd_pkg::ecsd_sel_t dec_sel;
  logic wait_hold;
  logic active_d;
  logic strobe_d;

  ecsd_decode u_decode (
    .addr(req.addr),
    .write(req.write),
    .isa4(cfg.sel4_isa),
    .isa5(cfg.sel5_isa),
    .sel(dec_sel)
  );

  // Wait only counts for selects whose configuration enables it
  assign wait_hold = (|(q.sel & cfg.wait_en)) && !q.wait_s;

  always_comb begin
    d = q;
    d.resp = 1'b0;
    d.wait_m = cycle_wait_n;
    d.wait_s = q.wait_m;
    d.ext_m = ext_master_req;
    d.ext_s = q.ext_m;
    d.pb4_m = port_b_bit_four_i;
    d.pb4_s = q.pb4_m;
    d.pb5_m = port_b_bit_five_i;
    d.pb5_s = q.pb5_m;
    d.a_m = addr_i;
    d.a_s = q.a_m;
    d.d_m = data_i;
    d.d_s = q.d_m;
    d.pb4_alt = cfg.pb4_alt;
    d.pb5_alt = cfg.pb5_alt;
    case (q.st)
      ecsd_pkg::ST_IDLE: begin
        if (req_valid && !q.ext_s) begin
          d.req = req;
          d.sel = dec_sel;
          d.isa4 = cfg.sel4_isa;
          d.isa5 = cfg.sel5_isa;
          d.cnt = 2'h0;
          d.st = ecsd_pkg::ST_SETUP;
        end
      end
      ecsd_pkg::ST_SETUP: begin
        d.st = ecsd_pkg::ST_STROBE;
      end
      ecsd_pkg::ST_STROBE: begin
        if (q.cnt != ecsd_pkg::STROBE_LAST) begin
          d.cnt = q.cnt + 2'h1;
        end else if (!wait_hold) begin
          d.st = ecsd_pkg::ST_HOLD;
        end
      end
      ecsd_pkg::ST_HOLD: begin
        d.st = ecsd_pkg::ST_DONE;
      end
      ecsd_pkg::ST_DONE: begin
        // Synchroniser now holds the pins as seen at the end of the strobe
        if (!q.req.write) begin
          d.rdata = q.d_s;
        end
        d.resp = 1'b1;
        d.st = ecsd_pkg::ST_IDLE;
      end
      default: begin
        d.st = ecsd_pkg::ST_IDLE;
      end
    endcase
    active_d = (d.st == ecsd_pkg::ST_SETUP) || (d.st == ecsd_pkg::ST_STROBE)
               || (d.st == ecsd_pkg::ST_HOLD);
    strobe_d = (d.st == ecsd_pkg::ST_STROBE);
    d.cs_n.boot = !(d.sel.boot && active_d);
    d.cs_n.ram = !(d.sel.ram && active_d);
    d.cs_n.two = !(d.sel.two && active_d);
    d.cs_n.four = !(d.sel.four
                    && (d.isa4 ? strobe_d : active_d));
    d.cs_n.five = !(d.sel.five
                    && (d.isa5 ? strobe_d : active_d));
    d.re_n = !(strobe_d && !d.req.write);
    d.we_n = !(strobe_d && d.req.write);
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      q <= '0;
      q.cs_n <= '1;
      q.re_n <= 1'b1;
      q.we_n <= 1'b1;
      q.wait_m <= 1'b1;
      q.wait_s <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign req_ready = (q.st == ecsd_pkg::ST_IDLE) && !q.ext_s;
  assign resp_valid = q.resp;
  assign resp_rdata = q.rdata;
  assign ext_master_active = q.ext_s && (q.st == ecsd_pkg::ST_IDLE);
  assign ext_addr = q.a_s;
  assign addr_o = q.req.addr[20:0];
  assign addr_oe = (q.st != ecsd_pkg::ST_IDLE);
  assign data_o = q.req.wdata;
  assign data_oe = q.req.write && (q.st != ecsd_pkg::ST_IDLE)
                   && (q.st != ecsd_pkg::ST_DONE);
  assign boot_select_n = q.cs_n.boot;
  assign ram_select_n = q.cs_n.ram;
  assign select_two_n = q.cs_n.two;
  // Select pins share port B; alternate use only once configured
  assign port_b_bit_four_o = q.pb4_alt ? q.cs_n.four
                             : gpio_b4_o;
  assign port_b_bit_four_oe = q.pb4_alt ? 1'b1 : gpio_b4_oe;
  assign port_b_bit_five_o = q.pb5_alt ? q.cs_n.five
                             : gpio_b5_o;
  assign port_b_bit_five_oe = q.pb5_alt ? 1'b1 : gpio_b5_oe;
  assign gpio_b4_i = q.pb4_s;
  assign gpio_b5_i = q.pb5_s;
  assign write_not_read = (q.st != ecsd_pkg::ST_IDLE)
                          && q.req.write;
  assign read_not_write = !write_not_read;
  assign read_strobe_n = q.re_n;
  assign write_strobe_n = q.we_n;

  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);

  one_select_a: assert property ($onehot0(~q.cs_n))
    else $error("more than one select active");

  boot_window_a: assert property (
    (q.st == ecsd_pkg::ST_SETUP) && (q.req.addr <= ecsd_pkg::BOOT_HI)
    |-> !boot_select_n && $past(req_ready))
    else $error("boot select missing in its window");

  boot_after_reset_a: assert property (
    $fell(srst) ##1 (req_valid && req_ready
    && (req.addr == ecsd_pkg::BOOT_LO)) |=> !boot_select_n)
    else $error("first fetch after reset missed boot select");

  ram_window_a: assert property (
    (q.st == ecsd_pkg::ST_SETUP)
    && ecsd_pkg::in_win(q.req.addr, ecsd_pkg::RAM_LO, ecsd_pkg::RAM_HI)
    |-> !ram_select_n [*2])
    else $error("ram select wrong");

  two_window_a: assert property (
    !select_two_n
    |-> ecsd_pkg::in_win(q.req.addr, ecsd_pkg::TWO_LO, ecsd_pkg::TWO_HI))
    else $error("select two outside its window");

  four_plain_a: assert property (
    (q.st == ecsd_pkg::ST_SETUP) && !q.isa4
    && ecsd_pkg::in_win(q.req.addr, ecsd_pkg::FOUR_LO, ecsd_pkg::FOUR_HI)
    |-> !q.cs_n.four)
    else $error("select four missing in ordinary window");

  four_isa_a: assert property (
    !q.cs_n.four && q.isa4
    |-> (q.st == ecsd_pkg::ST_STROBE) && !q.req.write && !read_strobe_n
    && ecsd_pkg::in_win(q.req.addr, ecsd_pkg::ISA_LO, ecsd_pkg::ISA_HI))
    else $error("read strobe select outside read cycle");

  five_plain_a: assert property (
    !q.cs_n.five && !q.isa5
    |-> ecsd_pkg::in_win(q.req.addr, ecsd_pkg::FIVE_LO, ecsd_pkg::FIVE_HI))
    else $error("select five outside its window");

  five_isa_a: assert property (
    !q.cs_n.five && q.isa5
    |-> (q.st == ecsd_pkg::ST_STROBE) && q.req.write && !write_strobe_n
    && ecsd_pkg::in_win(q.req.addr, ecsd_pkg::ISA_LO, ecsd_pkg::ISA_HI))
    else $error("write strobe select outside write cycle");

  port_b_reset_a: assert property (
    $past(srst) |-> !q.pb4_alt && !q.pb5_alt && (port_b_bit_four_o
    == gpio_b4_o) && (port_b_bit_five_oe == gpio_b5_oe))
    else $error("port B not general purpose after reset");

  addr_own_a: assert property (
    addr_oe |-> !ext_master_active && (addr_o == q.req.addr[20:0]))
    else $error("address driven while external master owns bus");

  data_dir_a: assert property (
    data_oe |-> write_not_read && read_strobe_n && q.req.write)
    else $error("data driven on a read");

  dir_pair_a: assert property (
    (q.st != ecsd_pkg::ST_IDLE)
    |-> (write_not_read == q.req.write) && (read_not_write != write_not_read))
    else $error("direction outputs wrong");

  wait_stretch_a: assert property (
    (q.st == ecsd_pkg::ST_STROBE) && (q.cnt == ecsd_pkg::STROBE_LAST)
    && wait_hold |=> (q.st == ecsd_pkg::ST_STROBE))
    else $error("cycle left strobe while held by wait");

  read_order_a: assert property (
    $fell(read_strobe_n) |-> $past(q.st) == ecsd_pkg::ST_SETUP
    && addr_oe && $past(addr_oe))
    else $error("read strobe before address valid");

  cycle_len_a: assert property (
    (req_valid && req_ready) ##1 (cfg.wait_en == 5'h00) [*6]
    |-> ##1 resp_valid)
    else $error("byte cycle did not end in seven cycles");

  resp_once_a: assert property (
    resp_valid |=> !resp_valid)
    else $error("response lasted more than one cycle");

  strobe_excl_a: assert property (
    read_strobe_n || write_strobe_n)
    else $error("read and write strobes active together");

  idle_dir_a: assert property (
    (q.st == ecsd_pkg::ST_IDLE) |-> !write_not_read && read_not_write)
    else $error("direction outputs wrong while idle");

  select_release_a: assert property (
    (q.st == ecsd_pkg::ST_DONE) |-> (q.cs_n == 5'h1F) && read_strobe_n)
    else $error("select still active after the cycle");

  write_order_a: assert property (
    $fell(write_strobe_n) |-> ($past(q.st) == ecsd_pkg::ST_SETUP)
    && data_oe && $past(data_oe))
    else $error("write strobe before data driven");

  wait_ignore_a: assert property (
    (q.st == ecsd_pkg::ST_STROBE) && (q.cnt == ecsd_pkg::STROBE_LAST)
    && !(|(q.sel & cfg.wait_en)) |=> (q.st == ecsd_pkg::ST_HOLD))
    else $error("cycle stretched by a wait it should ignore");

  ext_release_a: assert property (
    ext_master_active |-> !addr_oe && !data_oe && !req_ready)
    else $error("bus driven while external master active");

  pb4_mode_a: assert property (
    1'b1 |=> (q.pb4_alt == $past(cfg.pb4_alt))
    && (!q.pb4_alt || port_b_bit_four_oe))
    else $error("port B bit four mode not taken from configuration");

  pb5_mode_a: assert property (
    1'b1 |=> (q.pb5_alt == $past(cfg.pb5_alt))
    && (!q.pb5_alt || port_b_bit_five_oe))
    else $error("port B bit five mode not taken from configuration");

  addr_stable_a: assert property (
    (q.st == ecsd_pkg::ST_STROBE) |-> $stable(addr_o) && $past(addr_oe))
    else $error("address changed while strobe active");

  isa_read_c: cover property (!q.cs_n.four && q.isa4);
  isa_write_c: cover property (!q.cs_n.five && q.isa5);
  write_c: cover property (!write_strobe_n && !ram_select_n);
  wait_c: cover property ((wait_hold && (q.cnt == ecsd_pkg::STROBE_LAST))
                          [*3]);
  ext_c: cover property (ext_master_active);

endmodule

// ### testbench/ecsd_mem_model.sv
// Bus-side memory model: answers reads, records writes, stretches cycles
module ecsd_mem_model (
  input wire logic clock,
  input wire logic [20:0] addr_o,
  input wire logic addr_oe,
  input wire logic [7:0] data_o,
  input wire logic data_oe,
  input wire logic write_not_read,
  input wire logic write_strobe_n,
  input wire logic [4:0] sel_low,
  input wire logic [3:0] wait_len,
  output logic [7:0] data_i,
  output logic cycle_wait_n,
  output logic [7:0] wdata_seen
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] last_q = 8'h00;
  logic [3:0] cnt_q = 4'h0;
  logic drive;
  // Only a selected device answers a read
  assign drive = addr_oe && !write_not_read && (sel_low != 5'h00);
  // A released bus shows the inverse of its last level
  assign data_i = data_oe ? data_o : drive ? addr_o[7:0] ^ 8'h3C : ~last_q;
  // Hold wait low for wait_len cycles from address valid
  assign cycle_wait_n = !(addr_oe && (cnt_q < wait_len));
  always @(posedge clock) begin
    last_q <= data_i;
    cnt_q <= !addr_oe ? 4'h0 : (cnt_q == 4'hF) ? cnt_q : cnt_q + 4'h1;
    if (!write_strobe_n && data_oe) begin
      wdata_seen <= data_o;
    end
  end
endmodule

// ### testbench/tb.sv
// Self-checking bench for the chip-select decoder
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock, srst, req_valid, req_ready, resp_valid, ext_master_req;
  logic ext_master_active, addr_oe, data_oe, write_not_read, read_not_write;
  logic read_strobe_n, write_strobe_n, cycle_wait_n, cur_w;
  logic boot_select_n, ram_select_n, select_two_n, gpio_b4_i, gpio_b5_i;
  logic port_b_bit_four_o, port_b_bit_four_oe, port_b_bit_four_i;
  logic port_b_bit_five_o, port_b_bit_five_oe, port_b_bit_five_i;
  logic gpio_b4_o, gpio_b4_oe, gpio_b5_o, gpio_b5_oe;
  logic [7:0] resp_rdata, data_o, data_i, wseen;
  logic [20:0] addr_o, addr_i, ext_addr, ext_a;
  logic [3:0] wait_len;
  logic [4:0] seen, low, flags;
  ecsd_pkg::ecsd_cfg_t cfg;
  ecsd_pkg::ecsd_req_t req;
  int miscompares = 0;
  int cmp_count = 0;
  int n;

  // Pins: pull-ups on port B, external master drives address when released
  assign port_b_bit_four_i = port_b_bit_four_oe ? port_b_bit_four_o : 1'b1;
  assign port_b_bit_five_i = port_b_bit_five_oe ? port_b_bit_five_o : 1'b1;
  assign addr_i = addr_oe ? addr_o : ext_a;
  assign low = {~boot_select_n, ~ram_select_n, ~select_two_n,
                port_b_bit_four_oe & ~port_b_bit_four_o,
                port_b_bit_five_oe & ~port_b_bit_five_o};

  ecsd_top dut (.clock, .srst, .cfg, .req_valid, .req, .req_ready,
    .resp_valid, .resp_rdata, .gpio_b4_o, .gpio_b4_oe, .gpio_b4_i,
    .gpio_b5_o, .gpio_b5_oe, .gpio_b5_i, .ext_master_req, .ext_master_active,
    .ext_addr, .addr_o, .addr_oe, .addr_i, .data_o, .data_oe, .data_i,
    .boot_select_n, .ram_select_n, .select_two_n, .port_b_bit_four_o,
    .port_b_bit_four_oe, .port_b_bit_four_i, .port_b_bit_five_o,
    .port_b_bit_five_oe, .port_b_bit_five_i, .write_not_read,
    .read_not_write, .read_strobe_n, .write_strobe_n, .cycle_wait_n);

  ecsd_mem_model mem (.clock, .addr_o, .addr_oe, .data_o, .data_oe,
    .write_not_read, .write_strobe_n, .sel_low(low), .wait_len, .data_i,
    .cycle_wait_n, .wdata_seen(wseen));

  always @(posedge clock) begin
    seen <= seen | low;
    if (!read_strobe_n && (!addr_oe || write_not_read)) flags[0] <= 1'b1;
    if (addr_oe && (write_not_read !== cur_w || read_not_write !== !cur_w))
      flags[1] <= 1'b1;
    if (data_oe && !cur_w) flags[2] <= 1'b1;
    if ((low & (low - 5'h01)) != 5'h00) flags[3] <= 1'b1;
    if ((cfg.sel4_isa && low[1] && read_strobe_n) ||
        (cfg.sel5_isa && low[0] && write_strobe_n)) flags[4] <= 1'b1;
  end

  task automatic chk(string nm, logic [25:0] e, logic [25:0] s);
    cmp_count++;
    if (s !== e) begin
      miscompares++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // One bus cycle: hold the request until taken, then time the answer
  task automatic op(logic w, logic [25:0] a, logic [4:0] m, int lo = 6,
                    int hi = 6);
    @(posedge clock);
    #1;
    req = '{write: w, addr: a, wdata: a[7:0] ^ a[25:18] ^ 8'h5A};
    req_valid = 1'b1;
    cur_w = w;
    seen = 5'h00;
    flags = 5'h00;
    n = 0;
    while (!req_ready && n < 50) begin
      @(posedge clock);
      #1;
      n++;
    end
    chk("req_taken", 1'b1, n < 50);
    @(posedge clock);
    #1;
    req_valid = 1'b0;
    n = 0;
    while (!resp_valid && n < 40) begin
      @(posedge clock);
      #1;
      n++;
    end
    chk("latency_ok", 1'b1, (n >= lo) && (n <= hi));
    chk("selects", m, seen);
    if (!w && m != 5'h00)
      chk("rdata", a[7:0] ^ 8'h3C, resp_rdata);
    if (w) chk("wdata", a[7:0] ^ a[25:18] ^ 8'h5A, wseen);
    chk("flags", 5'h00, flags);
  endtask

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  initial begin
    #200000;
    miscompares++;
    give_verdict();
  end

  initial begin
    srst = 1'b1;
    req_valid = 1'b0;
    req = '0;
    cfg = '0;
    cur_w = 1'b0;
    ext_master_req = 1'b0;
    ext_a = 21'h00000;
    wait_len = 4'h0;
    gpio_b4_o = 1'b1;
    gpio_b4_oe = 1'b1;
    gpio_b5_o = 1'b0;
    gpio_b5_oe = 1'b0;
    repeat (8) @(posedge clock);
    #1;
    srst = 1'b0;
    chk("pb4_oe", 1'b1, port_b_bit_four_oe);
    chk("pb4_o", 1'b1, port_b_bit_four_o);
    chk("pb5_oe", 1'b0, port_b_bit_five_oe);
    op(1'b0, 26'h0000000, 5'h10);
    gpio_b4_o = 1'b0;
    gpio_b5_oe = 1'b1;
    repeat (3) @(posedge clock);
    #1;
    chk("gpio_b4_i", 1'b0, gpio_b4_i);
    chk("gpio_b5_i", 1'b0, gpio_b5_i);
    gpio_b4_o = 1'b1;
    gpio_b5_oe = 1'b0;
    op(1'b0, 26'h03FFFFF, 5'h10);
    op(1'b1, 26'h0400000, 5'h08);
    op(1'b0, 26'h07FFFFF, 5'h08);
    op(1'b1, 26'h0800000, 5'h04);
    op(1'b0, 26'h0BFFFFF, 5'h04);
    op(1'b0, 26'h0C000A5, 5'h00);
    op(1'b0, 26'h3400000, 5'h00);
    cfg.pb4_alt = 1'b1;
    cfg.pb5_alt = 1'b1;
    repeat (2) @(posedge clock);
    #1;
    op(1'b0, 26'h1000000, 5'h02);
    op(1'b1, 26'h13FFFFF, 5'h02);
    op(1'b1, 26'h1400000, 5'h01);
    op(1'b0, 26'h17FFFFF, 5'h01);
    cfg.sel4_isa = 1'b1;
    cfg.sel5_isa = 1'b1;
    op(1'b0, 26'h3400000, 5'h02);
    op(1'b1, 26'h37FFFFF, 5'h01);
    op(1'b0, 26'h1000000, 5'h00);
    op(1'b1, 26'h1400000, 5'h00);
    cfg.wait_en = 5'h10;
    wait_len = 4'h8;
    op(1'b0, 26'h0000000, 5'h10, 13, 13);
    cfg.wait_en = 5'h00;
    op(1'b0, 26'h0000000, 5'h10);
    ext_master_req = 1'b1;
    ext_a = 21'h15AC3;
    repeat (4) @(posedge clock);
    #1;
    chk("req_ready", 1'b0, req_ready);
    chk("addr_oe", 1'b0, addr_oe);
    chk("ext_active", 1'b1, ext_master_active);
    repeat (3) @(posedge clock);
    #1;
    chk("ext_addr", 21'h15AC3, ext_addr);
    ext_master_req = 1'b0;
    repeat (4) @(posedge clock);
    #1;
    chk("req_ready", 1'b1, req_ready);
    give_verdict();
  end
endmodule
